// ### logic/scd_pkg.sv
package scd_pkg;
  // clock and link timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BIT_RATE_BPS = 1000;
  localparam int EXEC_PULSE_MS = 50;
  localparam int EXEC_CYC_DFLT = EXEC_PULSE_MS * (CLK_HZ / 1000);
  // message format
  localparam int SYNC_ZEROS = 13;
  localparam int FRAME_BITS = 17;
  localparam int N_DEST = 8;
  localparam logic [4:0] VAL_PATTERN = 5'h1F;
  localparam logic [7:0] EXEC_CODE = 8'hA5;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ISTAT = 8'h08;
  localparam logic [7:0] OFS_IMASK = 8'h0C;
  localparam logic [7:0] OFS_TM = 8'h10;
  localparam logic [7:0] OFS_DEST = 8'h20;
  // control fields and reset values
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_DSEL_BIT = 7;
  localparam int CTRL_EN_BIT = 8;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic DSEL_RST = 1'b0;
  localparam logic EN_RST = 1'b1;
  localparam logic [3:0] IMASK_RST = 4'h0;
  // interrupt status bits
  localparam int IRQ_CMD = 0;
  localparam int IRQ_EXEC = 1;
  localparam int IRQ_REJ = 2;
  localparam int IRQ_QUIET = 3;
  localparam int N_IRQ = 4;

  typedef enum logic [2:0] {
    ST_QUIET = 3'b000,
    ST_HUNT = 3'b001,
    ST_CMD = 3'b010,
    ST_VAL = 3'b011,
    ST_WAIT = 3'b100
  } scd_state_e;

  typedef struct packed {
    logic [6:0] addr;
    logic dsel;
    logic [7:0] code;
    logic par;
  } scd_frame_s;

  typedef struct packed {
    logic car;
    logic tone;
    logic data;
  } scd_pins_s;

  // odd parity holds when the ones count is odd
  function automatic logic odd_ok(input logic [16:0] v);
    return ^v;
  endfunction
endpackage

// ### logic/scd_sync.sv
`timescale 1ns/100ps
module scd_sync import scd_pkg::*; (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  // pins
  input wire scd_pins_s d_i,
  output scd_pins_s q_o
);
  scd_pins_s meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ### logic/scd_pulse.sv
`timescale 1ns/100ps
module scd_pulse #(
  parameter int CYC = 5000000
) (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  // trigger and output
  input wire logic start_i,
  output logic act_o
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYC - 1);
  logic [CW-1:0] cnt_r;

  // a new start reloads, so back-to-back executes keep it high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      act_o <= 1'b0;
    end else if (start_i) begin
      cnt_r <= LOAD;
      act_o <= 1'b1;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      act_o <= 1'b0;
    end
  end
endmodule

// ### logic/scd_decoder.sv
`timescale 1ns/100ps
module scd_decoder import scd_pkg::*; #(
  parameter int EXEC_CYCLES = EXEC_CYC_DFLT,
  parameter int NDEST = N_DEST
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link pins
  input wire logic car_det_i,
  input wire logic bit_tone_i,
  input wire logic bit_data_i,
  // channel and value outputs
  output logic [7:0] chan_o,
  output logic matrix_en_o,
  output logic [NDEST-1:0][15:0] dest_o,
  // telemetry
  output logic [7:0] tm_cmd_o,
  output logic [15:0] tm_val_o,
  output logic data_present_o,
  output logic logic_pwr_o,
  output logic irq_o
);
  scd_pins_s pins_s;
  logic tone_d_r;
  logic bit_ev;
  logic dbit;
  scd_state_e state_r;
  logic [16:0] sh_r;
  logic [4:0] bc_r;
  logic [3:0] zc_r;
  scd_frame_s fr;
  logic stored_r;
  logic is_val_r;
  logic [15:0] val_r;
  logic fire_r;
  logic [N_IRQ-1:0] ev;
  logic [N_IRQ-1:0] ist_r;
  logic [N_IRQ-1:0] imask_r;
  logic [6:0] cfg_addr_r;
  logic cfg_dsel_r;
  logic cfg_en_r;
  logic wb_hit;
  logic wb_wr;
  logic cmd_ok;
  logic exec_ok;

  // pins come from outside the clock domain
  scd_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i('{car: car_det_i, tone: bit_tone_i, data: bit_data_i}),
    .q_o(pins_s)
  );

  // bit boundary is the rising edge of the bit tone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tone_d_r <= 1'b0;
    end else begin
      tone_d_r <= pins_s.tone;
    end
  end

  assign bit_ev = pins_s.tone & ~tone_d_r;
  assign dbit = pins_s.data;
  assign fr = scd_frame_s'({sh_r[15:0], dbit});
  assign cmd_ok = fr.addr == cfg_addr_r && fr.dsel == cfg_dsel_r && odd_ok({8'h00, fr.code, fr.par});
  assign exec_ok = cmd_ok && fr.code == EXEC_CODE;

  // serial shift register, msb first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= '0;
    end else if (bit_ev) begin
      sh_r <= {sh_r[15:0], dbit};
    end
  end

  // message sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_QUIET;
      bc_r <= '0;
      zc_r <= '0;
      stored_r <= 1'b0;
      is_val_r <= 1'b0;
      chan_o <= '0;
      val_r <= '0;
      fire_r <= 1'b0;
      ev <= '0;
    end else begin
      fire_r <= 1'b0;
      ev <= '0;
      if (!pins_s.car || !cfg_en_r) begin
        // subcarrier gone or decoder disabled: message over, logic idles
        ev[IRQ_QUIET] <= state_r != ST_QUIET;
        state_r <= ST_QUIET;
        stored_r <= 1'b0;
        bc_r <= '0;
        zc_r <= '0;
      end else begin
        case (state_r)
          ST_QUIET: begin
            state_r <= ST_HUNT;
            zc_r <= '0;
          end
          ST_HUNT: begin
            if (bit_ev) begin
              if (!dbit) begin
                zc_r <= (zc_r == 4'(SYNC_ZEROS)) ? zc_r : zc_r + 1'b1;
              end else if (zc_r == 4'(SYNC_ZEROS)) begin
                state_r <= ST_CMD;
                bc_r <= '0;
              end else begin
                zc_r <= '0;
              end
            end
          end
          ST_CMD: begin
            if (bit_ev) begin
              bc_r <= bc_r + 1'b1;
              if (bc_r == 5'(FRAME_BITS - 1)) begin
                bc_r <= '0;
                zc_r <= '0;
                if (cmd_ok) begin
                  chan_o <= fr.code;
                  stored_r <= 1'b1;
                  is_val_r <= fr.code[7:3] == VAL_PATTERN;
                  state_r <= (fr.code[7:3] == VAL_PATTERN) ? ST_VAL : ST_WAIT;
                  ev[IRQ_CMD] <= 1'b1;
                end else begin
                  state_r <= ST_HUNT;
                  ev[IRQ_REJ] <= 1'b1;
                end
              end
            end
          end
          ST_VAL: begin
            if (bit_ev) begin
              bc_r <= bc_r + 1'b1;
              if (bc_r == 5'(FRAME_BITS - 1)) begin
                bc_r <= '0;
                if (odd_ok({sh_r[15:0], dbit})) begin
                  val_r <= sh_r[15:0];
                  state_r <= ST_WAIT;
                end else begin
                  // whole message dropped, fresh sync needed
                  stored_r <= 1'b0;
                  state_r <= ST_HUNT;
                  zc_r <= '0;
                  ev[IRQ_REJ] <= 1'b1;
                end
              end
            end
          end
          ST_WAIT: begin
            // sliding window covers both zero train and back-to-back
            if (bit_ev) begin
              if (bc_r == 5'(FRAME_BITS - 1) && exec_ok) begin
                fire_r <= 1'b1;
                ev[IRQ_EXEC] <= 1'b1;
                bc_r <= '0;
              end else if (bc_r != 5'(FRAME_BITS - 1)) begin
                bc_r <= bc_r + 1'b1;
              end
            end
          end
          default: begin
            state_r <= ST_QUIET;
          end
        endcase
      end
    end
  end

  // channel drive; reloads keep it high across executes
  scd_pulse #(
    .CYC(EXEC_CYCLES)
  ) u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(fire_r),
    .act_o(matrix_en_o)
  );

  // parallel transfer of the held value
  generate
    for (genvar i = 0; i < NDEST; i++) begin : g_dest
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dest_o[i] <= '0;
        end else if (fire_r && is_val_r && chan_o[2:0] == 3'(i)) begin
          dest_o[i] <= val_r;
        end
      end
    end
  endgenerate

  // verification outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tm_cmd_o <= '0;
      tm_val_o <= '0;
      data_present_o <= 1'b0;
      logic_pwr_o <= 1'b0;
    end else begin
      tm_cmd_o <= chan_o;
      tm_val_o <= val_r;
      data_present_o <= state_r == ST_WAIT && stored_r;
      logic_pwr_o <= state_r != ST_QUIET;
    end
  end

  // wishbone: one wait state, ack for one cycle
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_addr_r <= ADDR_RST;
      cfg_dsel_r <= DSEL_RST;
      cfg_en_r <= EN_RST;
      imask_r <= IMASK_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
        cfg_addr_r <= wb_dat_i[CTRL_ADDR_LSB +: 7];
        cfg_dsel_r <= wb_dat_i[CTRL_DSEL_BIT];
      end
      if (wb_adr_i == OFS_CTRL && wb_sel_i[1]) begin
        cfg_en_r <= wb_dat_i[CTRL_EN_BIT];
      end
      if (wb_adr_i == OFS_IMASK && wb_sel_i[0]) begin
        imask_r <= wb_dat_i[N_IRQ-1:0];
      end
    end
  end

  // sticky status, write one to clear; a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_r <= '0;
    end else if (wb_wr && wb_adr_i == OFS_ISTAT && wb_sel_i[0]) begin
      ist_r <= (ist_r & ~wb_dat_i[N_IRQ-1:0]) | ev;
    end else begin
      ist_r <= ist_r | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ist_r & imask_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_hit && !wb_we_i) begin
      wb_dat_o <= '0;
      case (wb_adr_i)
        OFS_CTRL: wb_dat_o <= {23'h0, cfg_en_r, cfg_dsel_r, cfg_addr_r};
        OFS_STAT: wb_dat_o <= {26'h0, logic_pwr_o, matrix_en_o, data_present_o, state_r};
        OFS_ISTAT: wb_dat_o <= {28'h0, ist_r};
        OFS_IMASK: wb_dat_o <= {28'h0, imask_r};
        OFS_TM: wb_dat_o <= {val_r, 8'h00, chan_o};
        default: begin
          if (wb_adr_i >= OFS_DEST && wb_adr_i < OFS_DEST + 8'(4 * NDEST)) begin
            wb_dat_o <= {16'h0000, dest_o[wb_adr_i[4:2]]};
          end
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sync_seen;
    state_r == ST_HUNT ##1 state_r == ST_CMD;
  endsequence

  sequence s_exec_fire;
    fire_r ##1 matrix_en_o;
  endsequence

  property p_sync;
    s_sync_seen |-> $past(zc_r) == 4'(SYNC_ZEROS) && $past(dbit) && $past(bit_ev);
  endproperty
  a_sync: assert property (p_sync) else $error("message start without full sync");

  property p_quiet;
    !pins_s.car |=> state_r == ST_QUIET ##1 !logic_pwr_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("no quiescent after carrier loss");

  property p_exec_rise;
    $rose(matrix_en_o) |-> $past(fire_r);
  endproperty
  a_exec_rise: assert property (p_exec_rise) else $error("matrix enabled without execute");

  property p_exec_hold;
    s_exec_fire |-> matrix_en_o [*8];
  endproperty
  a_exec_hold: assert property (p_exec_hold) else $error("execute pulse ended early");

  property p_retrig;
    fire_r && matrix_en_o |=> matrix_en_o ##1 matrix_en_o;
  endproperty
  a_retrig: assert property (p_retrig) else $error("gap between repeated executes");

  property p_dp;
    data_present_o |-> $past(state_r) == ST_WAIT && $past(stored_r);
  endproperty
  a_dp: assert property (p_dp) else $error("data present without stored command");

  property p_val_par;
    state_r == ST_VAL && bit_ev && bc_r == 5'(FRAME_BITS - 1) && !odd_ok({sh_r[15:0], dbit})
      |=> state_r == ST_HUNT && !stored_r ##1 !data_present_o;
  endproperty
  a_val_par: assert property (p_val_par) else $error("bad value parity not discarded");

  property p_xfer;
    fire_r && is_val_r |=> dest_o[$past(chan_o[2:0])] == $past(val_r);
  endproperty
  a_xfer: assert property (p_xfer) else $error("value not transferred");

  property p_addr;
    state_r == ST_CMD ##1 state_r == ST_WAIT || state_r == ST_VAL
      |-> $past(sh_r[15:9]) == cfg_addr_r && $past(sh_r[8]) == cfg_dsel_r;
  endproperty
  a_addr: assert property (p_addr) else $error("command accepted with wrong address");

  property p_tm;
    state_r == ST_WAIT ##1 state_r == ST_WAIT ##1 state_r == ST_WAIT
      |-> tm_cmd_o == chan_o && tm_val_o == val_r;
  endproperty
  a_tm: assert property (p_tm) else $error("telemetry does not show stored data");
endmodule

// ### verification/scd_encoder_model.sv
`timescale 1ns/100ps
module scd_encoder_model import scd_pkg::*; (
  // link pins
  output scd_pins_s pins_o
);
  initial pins_o = '0;
  // data moves on the tone fall, so it is settled at the sampling rise
  task automatic tx(input logic b);
    pins_o.tone = 1'b0;
    pins_o.data = b;
    #40;
    pins_o.tone = 1'b1;
    #40;
  endtask
  task automatic zeros(input int n);
    repeat (n) tx(1'b0);
  endtask
  task automatic start(input int n);
    pins_o.car = 1'b1;
    #80;
    zeros(n);
    tx(1'b1);
  endtask
  // msb first; no idle bits, so frames may follow back to back
  task automatic frame(input logic [16:0] f);
    for (int i = 16; i >= 0; i--) tx(f[i]);
  endtask
  // carrier gone: tone stands still, data is no longer meaningful
  task automatic stop();
    pins_o.tone = 1'b0;
    pins_o.car = 1'b0;
    pins_o.data = ~pins_o.data;
    #(28 * 80);
  endtask
endmodule

// ### verification/scd_decoder_test.sv
`timescale 1ns/100ps
module scd_decoder_test;
  import scd_pkg::*;
  localparam int EXEC_CYC = 200;
  localparam logic [6:0] ADDR = 7'h2B;
  logic clk, rst, cyc, stb, we, ack, mat, dp, pwr, irq;
  logic [7:0] adr, chan, tmc;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [15:0] tmv;
  logic [7:0][15:0] dest;
  logic [16:0] bad [3];
  scd_pins_s pins;
  int miscompares, checks, cyc_cnt;

  scd_encoder_model scd_encoder_model_inst (.pins_o(pins));
  scd_decoder #(.EXEC_CYCLES(EXEC_CYC)) scd_decoder_inst (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .car_det_i(pins.car),
    .bit_tone_i(pins.tone), .bit_data_i(pins.data), .chan_o(chan), .matrix_en_o(mat),
    .dest_o(dest), .tm_cmd_o(tmc), .tm_val_o(tmv), .data_present_o(dp), .logic_pwr_o(pwr),
    .irq_o(irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) chk1(ack, 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_mat();
    int n;
    n = 0;
    while (mat !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk1(mat, 1'b1);
  endtask
  function automatic logic [16:0] cf(input logic [7:0] c);
    return {ADDR, 1'b0, c, ~^c};
  endfunction

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    gap(8);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h00000100);
    rd(OFS_IMASK, 32'h0);
    // only lane 1 enabled: enable cleared, address lane untouched
    sel <= 4'h2;
    wr(OFS_CTRL, 32'h0000007F);
    rd(OFS_CTRL, 32'h00000000);
    sel <= 4'hF;
    wr(8'h44, 32'hFFFFFFFF);
    rd(8'h44, 32'h0);
    wr(OFS_CTRL, {23'h0, 1'b1, 1'b0, ADDR});
    wr(OFS_IMASK, 32'h2);
    // value command held for ground check, then two executes
    scd_encoder_model_inst.start(13);
    scd_encoder_model_inst.frame(cf(8'hFD));
    scd_encoder_model_inst.frame({16'hA35C, ~^16'hA35C});
    scd_encoder_model_inst.zeros(34);
    gap(4);
    chk1(dp, 1'b1);
    chk1(pwr, 1'b1);
    chk({tmv, 8'h0, tmc}, 32'hA35C00FD);
    rd(OFS_TM, 32'hA35C00FD);
    chk({16'h0, dest[5]}, 32'h0);
    chk1(mat, 1'b0);
    scd_encoder_model_inst.frame(cf(EXEC_CODE));
    wait_mat();
    chk({16'h0, dest[5]}, 32'hA35C);
    chk({24'h0, chan}, 32'hFD);
    // irq lags the status and mask flops by one edge
    gap(2);
    chk1(irq, 1'b1);
    wr(OFS_IMASK, 32'h0);
    gap(1);
    chk1(irq, 1'b0);
    wr(OFS_IMASK, 32'h2);
    gap(1);
    chk1(irq, 1'b1);
    wr(OFS_ISTAT, 32'h2);
    gap(1);
    chk1(irq, 1'b0);
    scd_encoder_model_inst.frame(cf(EXEC_CODE));
    gap(190);
    chk1(mat, 1'b1);
    gap(20);
    chk1(mat, 1'b0);
    scd_encoder_model_inst.stop();
    chk1(pwr, 1'b0);
    chk1(dp, 1'b0);
    rd(OFS_STAT, 32'h0);
    // execute straight after the command frame
    scd_encoder_model_inst.start(13);
    scd_encoder_model_inst.frame(cf(8'h42));
    scd_encoder_model_inst.frame(cf(EXEC_CODE));
    wait_mat();
    chk({24'h0, chan}, 32'h42);
    chk({16'h0, dest[5]}, 32'hA35C);
    scd_encoder_model_inst.stop();
    chk1(mat, 1'b0);
    // value parity broken: nothing may land
    scd_encoder_model_inst.start(13);
    scd_encoder_model_inst.frame(cf(8'hF9));
    scd_encoder_model_inst.frame({16'h1234, ^16'h1234});
    scd_encoder_model_inst.frame(cf(EXEC_CODE));
    gap(10);
    chk1(mat, 1'b0);
    chk({16'h0, dest[1]}, 32'h0);
    scd_encoder_model_inst.stop();
    // wrong address, wrong select, wrong command parity
    bad[0] = {7'h2A, 1'b0, 8'h42, 1'b1};
    bad[1] = {ADDR, 1'b1, 8'h42, 1'b1};
    bad[2] = {ADDR, 1'b0, 8'h42, 1'b0};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_ISTAT, 32'hF);
      scd_encoder_model_inst.start(13);
      scd_encoder_model_inst.frame(bad[i]);
      gap(4);
      chk1(dp, 1'b0);
      rd(OFS_ISTAT, 32'h4);
      scd_encoder_model_inst.stop();
    end
    // one zero short of a valid sync
    scd_encoder_model_inst.start(12);
    scd_encoder_model_inst.frame(cf(8'h42));
    gap(4);
    chk1(dp, 1'b0);
    scd_encoder_model_inst.stop();
    // interval in mid-message drops the stored command
    scd_encoder_model_inst.start(13);
    scd_encoder_model_inst.frame(cf(8'h42));
    gap(4);
    chk1(dp, 1'b1);
    scd_encoder_model_inst.stop();
    chk1(dp, 1'b0);
    scd_encoder_model_inst.start(13);
    scd_encoder_model_inst.frame(cf(EXEC_CODE));
    gap(10);
    chk1(mat, 1'b0);
    scd_encoder_model_inst.stop();
    test_done();
  end
endmodule
